/* cdp_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RQ1] Fetch 24-bit words, variable-length opcode field
// [RQ2] 23-bit program counter over 4M words
// [RQ3] Prefetch next word one cycle ahead
// [RQ4] Single cycle except jumps, double move
// [RQ5] Repeat loop, zero overhead, interruptible each pass
// [RQ6] Sixteen 16-bit registers: data, pointer, offset
// [RQ7] Last register is stack pointer for interrupts
// [RQ8] Read, register read, write, fetch per cycle
// [RQ9] Linear 64-Kbyte data address space
// [RQ10] Upper half maps to program page window
// [RQ11] Flag accesses in 2-Kbyte DMA region; the code flags reads only, not writes
// [RQ12] 17x17 multiplier, signed, unsigned, mixed sign
// [RQ13] Divide 16/16 and 32/16, signed or unsigned
// [RQ14] Divide repeated in loop, 19 cycles total
// [RQ15] Interrupt mid-divide keeps partial result intact
// [RQ16] Shift up to 16 positions, one cycle
// [RQ17] Signed amount: positive right, negative left
// [RQ18] Quotient to first, remainder to second register
// [RQ19] One divide step per divisor bit
// [RQ20] Reset clears PC, registers, page, window
module cdp_core
  import cdp_pkg::*;
#(
  parameter logic [DW-1:0] DMA_BASE = 16'h4000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  output logic [PC_W-1:0] progAddr,
  input wire logic [INSTR_W-1:0] progRdData,
  output logic [DW-1:0] dataRdAddr,
  output logic dataRdEn,
  input wire logic [DW-1:0] dataRdData,
  output logic [DW-1:0] dataWrAddr,
  output logic [DW-1:0] dataWrData,
  output logic dataWrEn,
  output logic dataDmaHit,
  input wire logic irqReq,
  input wire logic [PC_W-1:0] irqVector,
  output logic irqAck,
  output logic inIsr,
  output logic rptActive,
  output logic psvEnable,
  output logic [PSV_PAGE_W-1:0] psvPage
);

  typedef struct packed {
    cdp_state_t st;
    logic [15:0][DW-1:0] wreg;
    logic [PC_W-1:0] fetchPc;
    logic [PC_W-1:0] progAddr;
    logic [INSTR_W-1:0] instr;
    logic [PC_W-1:0] instrPc;
    logic instrVld;
    logic rdPsv;
    logic [RPT_W-1:0] rptCnt;
    logic rptActive;
    logic inIsr;
    logic psvEn;
    logic [PSV_PAGE_W-1:0] psvPage;
    logic [DW-1:0] retHi;
    logic [DW-1:0] dataRdAddr;
    logic dataRdEn;
    logic [DW-1:0] dataWrAddr;
    logic [DW-1:0] dataWrData;
    logic dataWrEn;
    logic dataDmaHit;
    logic irqAck;
  } cdp_core_state_t;

  cdp_core_state_t s_r;
  cdp_core_state_t s_nxt;

  // ============================================================
  // Helpers
  function automatic logic [3:0] cdp_fld(input logic [INSTR_W-1:0] ins, input int lsb);
    return ins[lsb +: 4];
  endfunction : cdp_fld

  function automatic logic [DW-1:0] cdp_alu(input logic [3:0] fn, input logic [DW-1:0] a, input logic [DW-1:0] b);
    case (fn)
      FN_ADD: return a + b;
      FN_SUB: return a - b;
      FN_AND: return a & b;
      FN_OR: return a | b;
      FN_XOR: return a ^ b;
      default: return a;
    endcase
  endfunction : cdp_alu

  // Amounts beyond 16 saturate, so any register value is a legal amount
  function automatic logic [DW-1:0] cdp_shift(input logic [DW-1:0] v, input logic [DW-1:0] amt, input logic arith);
    logic [DW-1:0] mag;
    logic [4:0] m;
    logic signed [DW:0] ext;
    mag = amt[DW-1] ? (16'h0 - amt) : amt;
    m = (mag > 16'h0010) ? SHIFT_MAX : mag[4:0]; // RQ16
    ext = {arith & v[DW-1], v};
    if (amt[DW-1]) begin
      return v << m; // RQ17
    end
    return DW'(ext >>> m); // RQ17
  endfunction : cdp_shift

  // ============================================================
  // Decode of the executing word
  logic [3:0] op;
  logic isGoto;
  logic [3:0] wdIdx;
  logic [3:0] waIdx;
  logic [3:0] wbIdx;
  logic [3:0] pairLo;
  logic [DW-1:0] opA;
  logic [DW-1:0] opB;
  logic [DW-1:0] rdVal;
  logic [DW:0] mulA;
  logic [DW:0] mulB;
  logic signed [33:0] product;
  logic [1:0] mulMode;
  logic divStep;
  logic divLast;
  logic [DW-1:0] divQuot;
  logic [DW-1:0] divRem;
  logic adv;
  logic [INSTR_W-1:0] ins;
  logic [3:0] insOp;
  logic isLoad;
  logic psvHit;
  logic [DW-1:0] issueAddr;

  assign op = s_r.instr[OP_LSB +: 4];
  assign isGoto = (s_r.instr[INSTR_W-1 -: 2] == OP_GOTO_PFX); // RQ1
  assign wdIdx = cdp_fld(s_r.instr, WD_LSB);
  assign waIdx = cdp_fld(s_r.instr, WA_LSB);
  assign wbIdx = cdp_fld(s_r.instr, WB_LSB);
  assign pairLo = {wdIdx[3:1], 1'b0};
  assign opA = s_r.wreg[waIdx];
  assign opB = s_r.wreg[wbIdx];
  assign mulMode = s_r.instr[MULMODE_LSB +: 2];
  assign mulA = {(mulMode == MUL_SS || mulMode == MUL_SU) & opA[DW-1], opA}; // RQ12
  assign mulB = {(mulMode == MUL_SS || mulMode == MUL_US) & opB[DW-1], opB}; // RQ12
  assign product = $signed(mulA) * $signed(mulB);
  // A store presented this cycle is not yet in memory, so its data is forwarded
  assign rdVal = (s_r.dataWrEn && s_r.dataWrAddr == s_r.dataRdAddr && !s_r.rdPsv) ? s_r.dataWrData :
                 (s_r.rdPsv ? progRdData[DW-1:0] : dataRdData); // RQ10

  cdp_divider u_divider (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .stepEn(divStep),
    .signedMode(s_r.instr[SIGNED_BIT]),
    .longMode(s_r.instr[LONG_BIT]),
    .dividend({s_r.wreg[{wdIdx[3:1], 1'b1}], s_r.wreg[wdIdx]}),
    .divisor(s_r.wreg[waIdx]),
    .lastStep(divLast),
    .busy(),
    .quotient(divQuot),
    .remainder(divRem)
  );

  // ============================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.irqAck = 1'b0;
    s_nxt.dataWrEn = 1'b0;
    adv = 1'b0;
    divStep = 1'b0;
    case (s_r.st)
      ST_RUN: begin
        if (!s_r.instrVld) begin
          adv = 1'b1;
        end else if (irqReq && !s_r.inIsr) begin
          // Taken in place of the pending word; a repeated word resumes with its count untouched
          s_nxt.dataWrAddr = s_r.wreg[SP_IDX]; // RQ7
          s_nxt.dataWrData = s_r.instrPc[DW-1:0];
          s_nxt.dataWrEn = 1'b1;
          s_nxt.wreg[SP_IDX] = s_r.wreg[SP_IDX] + WORD_STEP; // RQ7
          s_nxt.instrVld = 1'b0; // RQ5 RQ15
          s_nxt.rdPsv = 1'b0;
          s_nxt.dataRdEn = 1'b0;
          s_nxt.st = ST_IRQ_HI;
        end else if (isGoto) begin
          s_nxt.fetchPc = {s_r.instr[GOTO_TGT_W-1:0], 1'b0}; // RQ4
          s_nxt.progAddr = {s_r.instr[GOTO_TGT_W-1:0], 1'b0};
          s_nxt.instrVld = 1'b0;
          s_nxt.rdPsv = 1'b0;
          s_nxt.rptActive = 1'b0;
        end else begin
          adv = 1'b1;
          case (op)
            OP_ALU: s_nxt.wreg[wdIdx] = cdp_alu(s_r.instr[FN_LSB +: 4], opA, opB); // RQ8
            OP_MOVL: s_nxt.wreg[cdp_fld(s_r.instr, LIT_WD_LSB)] = s_r.instr[DW-1:0];
            OP_LD: s_nxt.wreg[cdp_fld(s_r.instr, LIT_WD_LSB)] = rdVal; // RQ8
            OP_ST: begin
              s_nxt.dataWrAddr = s_r.wreg[wdIdx] + s_r.wreg[waIdx]; // RQ6 RQ9
              s_nxt.dataWrData = s_r.wreg[cdp_fld(s_r.instr, LIT_WD_LSB)]; // RQ8
              s_nxt.dataWrEn = 1'b1;
            end
            OP_MUL: begin
              s_nxt.wreg[pairLo] = product[DW-1:0]; // RQ12
              s_nxt.wreg[{wdIdx[3:1], 1'b1}] = product[31:16];
            end
            OP_SHF: s_nxt.wreg[wdIdx] = cdp_shift(opA, opB, s_r.instr[SIGNED_BIT]); // RQ16
            OP_DIV: begin
              divStep = 1'b1; // RQ14
              if (divLast) begin
                s_nxt.wreg[QUOT_IDX] = divQuot; // RQ18
                s_nxt.wreg[REM_IDX] = divRem; // RQ18
              end
            end
            OP_RPT: begin
              s_nxt.rptCnt = s_r.instr[RPT_W-1:0]; // RQ5
              s_nxt.rptActive = (s_r.instr[RPT_W-1:0] != 14'h0000);
            end
            OP_RETI: begin
              adv = 1'b0;
              s_nxt.dataRdAddr = s_r.wreg[SP_IDX] - WORD_STEP; // RQ7
              s_nxt.dataRdEn = 1'b1;
              s_nxt.instrVld = 1'b0;
              s_nxt.rdPsv = 1'b0;
              s_nxt.st = ST_RET_HI;
            end
            OP_MOVD: begin
              // Second word needs a second read slot on the data bus; the fetch bus goes back to the next word
              adv = 1'b0;
              s_nxt.wreg[pairLo] = rdVal; // RQ4
              s_nxt.dataRdAddr = s_r.dataRdAddr + WORD_STEP;
              s_nxt.dataRdEn = 1'b1;
              s_nxt.rdPsv = 1'b0;
              s_nxt.progAddr = s_r.fetchPc;
              s_nxt.st = ST_MOVD_HI;
            end
            OP_PSV: begin
              s_nxt.psvEn = s_r.instr[PSV_EN_BIT]; // RQ10
              s_nxt.psvPage = s_r.instr[PSV_PAGE_W-1:0];
            end
            default: begin
            end
          endcase
          // Hold the repeated word in place, no refetch and no extra cycle
          if (adv && s_r.rptActive && op != OP_RPT) begin
            if (s_r.rptCnt != 14'h0000) begin
              s_nxt.rptCnt = s_r.rptCnt - 14'h0001; // RQ5
              adv = 1'b0;
            end else begin
              s_nxt.rptActive = 1'b0;
            end
          end
        end
      end
      ST_IRQ_HI: begin
        s_nxt.dataWrAddr = s_r.wreg[SP_IDX];
        s_nxt.dataWrData = {s_r.rptActive, 8'h00, s_r.instrPc[PC_W-1:DW]};
        s_nxt.dataWrEn = 1'b1;
        s_nxt.wreg[SP_IDX] = s_r.wreg[SP_IDX] + WORD_STEP; // RQ7
        s_nxt.fetchPc = irqVector;
        s_nxt.progAddr = irqVector;
        s_nxt.inIsr = 1'b1;
        s_nxt.rptActive = 1'b0;
        s_nxt.irqAck = 1'b1;
        s_nxt.st = ST_RUN;
      end
      ST_RET_HI: begin
        s_nxt.retHi = rdVal;
        s_nxt.dataRdAddr = s_r.wreg[SP_IDX] - DBL_STEP;
        s_nxt.st = ST_RET_LO;
      end
      ST_RET_LO: begin
        s_nxt.fetchPc = {s_r.retHi[PC_W-DW-1:0], rdVal};
        s_nxt.progAddr = {s_r.retHi[PC_W-DW-1:0], rdVal};
        s_nxt.rptActive = s_r.retHi[DW-1]; // RQ5 RQ15
        s_nxt.wreg[SP_IDX] = s_r.wreg[SP_IDX] - DBL_STEP;
        s_nxt.inIsr = 1'b0;
        s_nxt.dataRdEn = 1'b0;
        s_nxt.st = ST_RUN;
      end
      ST_MOVD_HI: begin
        s_nxt.wreg[{wdIdx[3:1], 1'b1}] = rdVal; // RQ4
        adv = 1'b1;
        s_nxt.st = ST_RUN;
      end
      default: s_nxt.st = ST_RUN;
    endcase

    // Issue: latch the prefetched word and start its data read from the updated registers
    ins = progRdData;
    insOp = ins[OP_LSB +: 4];
    isLoad = (ins[INSTR_W-1 -: 2] != OP_GOTO_PFX) && (insOp == OP_LD || insOp == OP_MOVD);
    issueAddr = s_nxt.wreg[cdp_fld(ins, WD_LSB)] + ((insOp == OP_LD) ? s_nxt.wreg[cdp_fld(ins, WA_LSB)] : WREG_RST); // RQ6
    psvHit = isLoad && s_nxt.psvEn && issueAddr[DW-1]; // RQ10
    if (adv) begin
      if (s_r.rdPsv) begin
        s_nxt.instrVld = 1'b0;
        s_nxt.rdPsv = 1'b0;
        s_nxt.progAddr = s_r.fetchPc;
      end else begin
        s_nxt.instr = ins; // RQ1 RQ3
        s_nxt.instrPc = s_r.fetchPc;
        s_nxt.instrVld = 1'b1;
        s_nxt.fetchPc = s_r.fetchPc + PC_STEP; // RQ2
        s_nxt.dataRdAddr = issueAddr; // RQ9
        s_nxt.dataRdEn = isLoad && !psvHit; // RQ8
        s_nxt.rdPsv = psvHit;
        s_nxt.progAddr = psvHit ? {s_nxt.psvPage, issueAddr[PSV_OFS_W-1:0]} : s_r.fetchPc + PC_STEP; // RQ10 RQ3
      end
    end
    // Follows every live read, the second word of a pair and the stack pops included
    s_nxt.dataDmaHit = s_nxt.dataRdEn && s_nxt.dataRdAddr >= DMA_BASE
                       && (s_nxt.dataRdAddr - DMA_BASE) < DMA_SIZE; // RQ11
  end

  // All reset values are zero, which is also the run state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r <= '0; // RQ20
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign progAddr = s_r.progAddr;
  assign dataRdAddr = s_r.dataRdAddr;
  assign dataRdEn = s_r.dataRdEn;
  assign dataWrAddr = s_r.dataWrAddr;
  assign dataWrData = s_r.dataWrData;
  assign dataWrEn = s_r.dataWrEn;
  assign dataDmaHit = s_r.dataDmaHit;
  assign irqAck = s_r.irqAck;
  assign inIsr = s_r.inIsr;
  assign rptActive = s_r.rptActive;
  assign psvEnable = s_r.psvEn;
  assign psvPage = s_r.psvPage;

endmodule : cdp_core
`default_nettype wire

/* cdp_core_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port-level checks of the execution core
module cdp_core_properties
  import cdp_pkg::*;
#(
  parameter logic [DW-1:0] DMA_BASE = 16'h4000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [PC_W-1:0] progAddr,
  input wire logic [DW-1:0] dataRdAddr,
  input wire logic dataRdEn,
  input wire logic [DW-1:0] dataWrAddr,
  input wire logic dataWrEn,
  input wire logic dataDmaHit,
  input wire logic irqReq,
  input wire logic [PC_W-1:0] irqVector,
  input wire logic irqAck,
  input wire logic inIsr,
  input wire logic rptActive,
  input wire logic psvEnable,
  input wire logic [PSV_PAGE_W-1:0] psvPage
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RST_CLEAR: assert property (
    $rose(rst_b) |-> progAddr == PC_RST && !psvEnable && psvPage == PSV_PAGE_RST && !dataWrEn && !inIsr)
    else $error("state not clear after reset");
  AST_ACK_VECTOR: assert property (
    irqAck |-> progAddr == irqVector)
    else $error("fetch address differs from vector at ack");
  AST_ACK_PULSE: assert property (
    irqAck && ce |=> !irqAck)
    else $error("ack longer than one cycle");
  AST_ACK_ENTERS: assert property (
    irqAck && ce |=> inIsr)
    else $error("service flag missing after ack");
  AST_ISR_BLOCK: assert property (
    inIsr && $past(inIsr) && $past(ce) |-> !irqAck)
    else $error("nested interrupt taken");
  AST_ACK_WITHIN: assert property (
    $rose(irqReq) && !inIsr |-> ##[1:24] irqAck)
    else $error("interrupt not taken in time");
  AST_SP_PUSH: assert property (
    irqAck && $past(ce) |->
      dataWrEn && $past(dataWrEn) && dataWrAddr == $past(dataWrAddr) + WORD_STEP)
    else $error("stack push pair missing");
  AST_DMA_FLAG: assert property (
    dataRdEn |-> dataDmaHit == ({1'b0, dataRdAddr} >= {1'b0, DMA_BASE}
      && {1'b0, dataRdAddr} < {1'b0, DMA_BASE} + {1'b0, DMA_SIZE}))
    else $error("region flag wrong");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(progAddr) && $stable(psvPage) && $stable(rptActive))
    else $error("state moved while disabled");

  cover property (irqAck);
  cover property ($rose(rptActive));
  cover property (dataRdEn && dataDmaHit);
  cover property (psvEnable);
endmodule : cdp_core_properties

bind cdp_core cdp_core_properties #(.DMA_BASE(DMA_BASE)) u_cdp_core_properties (
  .clk(clk), .rst_b(rst_b), .ce(ce), .progAddr(progAddr), .dataRdAddr(dataRdAddr),
  .dataRdEn(dataRdEn), .dataWrAddr(dataWrAddr), .dataWrEn(dataWrEn), .dataDmaHit(dataDmaHit),
  .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck), .inIsr(inIsr),
  .rptActive(rptActive), .psvEnable(psvEnable), .psvPage(psvPage)
);
`default_nettype wire

/* cdp_divider.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Iterative restoring divider, one step per enabled cycle
module cdp_divider
  import cdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic stepEn,
  input wire logic signedMode,
  input wire logic longMode,
  input wire logic [31:0] dividend,
  input wire logic [DW-1:0] divisor,
  output logic lastStep,
  output logic busy,
  output logic [DW-1:0] quotient,
  output logic [DW-1:0] remainder
);

  typedef struct packed {
    logic [4:0] cnt;
    logic [DW:0] rem;
    logic [DW-1:0] quo;
    logic [DW-1:0] dvs;
    logic negQ;
    logic negR;
  } cdp_div_state_t;

  cdp_div_state_t s_r;
  cdp_div_state_t s_nxt;

  logic [31:0] dvdExt;
  logic [31:0] dvdAbs;
  logic [DW:0] shifted;
  logic [DW:0] trial;

  always_comb begin
    s_nxt = s_r;
    // Operands are only sampled at the load step, so an interrupt between steps leaves nothing to corrupt
    dvdExt = longMode ? dividend : {{DW{signedMode & dividend[DW-1]}}, dividend[DW-1:0]}; // RQ13
    dvdAbs = (signedMode && dvdExt[31]) ? (32'h0 - dvdExt) : dvdExt;
    shifted = {s_r.rem[DW-1:0], s_r.quo[DW-1]};
    trial = shifted - {1'b0, s_r.dvs};
    if (stepEn) begin
      if (s_r.cnt == 5'h00) begin
        s_nxt.rem = {1'b0, dvdAbs[31:16]};
        s_nxt.quo = dvdAbs[15:0];
        s_nxt.dvs = (signedMode && divisor[DW-1]) ? (16'h0 - divisor) : divisor;
        s_nxt.negQ = signedMode & (dvdExt[31] ^ divisor[DW-1]);
        s_nxt.negR = signedMode & dvdExt[31];
        s_nxt.cnt = 5'h01;
      end else if (s_r.cnt == DIV_LAST) begin
        s_nxt.cnt = 5'h00;
      end else begin
        // One quotient bit per divisor bit, whatever the dividend width
        s_nxt.rem = trial[DW] ? shifted : trial; // RQ19
        s_nxt.quo = {s_r.quo[DW-2:0], ~trial[DW]};
        s_nxt.cnt = s_r.cnt + 5'h01;
      end
    end
  end

  assign lastStep = (s_r.cnt == DIV_LAST);
  assign busy = (s_r.cnt != 5'h00);
  assign quotient = s_r.negQ ? (16'h0 - s_r.quo) : s_r.quo;
  assign remainder = s_r.negR ? (16'h0 - s_r.rem[DW-1:0]) : s_r.rem[DW-1:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

endmodule : cdp_divider
`default_nettype wire

/* cdp_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Program and data memories, asynchronous read
module cdp_mem_model
  import cdp_pkg::*;
(
  input wire logic clk,
  input wire logic [PC_W-1:0] progAddr,
  output logic [INSTR_W-1:0] progRdData,
  input wire logic [DW-1:0] dataRdAddr,
  input wire logic dataRdEn,
  output logic [DW-1:0] dataRdData,
  input wire logic [DW-1:0] dataWrAddr,
  input wire logic [DW-1:0] dataWrData,
  input wire logic dataWrEn
);
  logic [INSTR_W-1:0] prog [0:1023] = '{default: 24'h0};
  logic [DW-1:0] mem [0:32767];
  logic [DW-1:0] lastRd = 16'h0;

  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = DW'(2 * i) ^ 16'h5a5a;
  end

  // Small program store aliases high addresses
  assign progRdData = prog[progAddr[10:1]];
  // Unselected reads show the inverse so stale data cannot pass
  assign dataRdData = dataRdEn ? mem[dataRdAddr[15:1]] : ~lastRd;

  always @(posedge clk) begin
    if (dataRdEn) lastRd <= mem[dataRdAddr[15:1]];
    if (dataWrEn) mem[dataWrAddr[15:1]] <= dataWrData;
  end
endmodule : cdp_mem_model
`default_nettype wire

/* cdp_pkg.sv */
// ============================================================
// Shared constants and types of the execution core
package cdp_pkg;

  // ============================================================
  // Widths
  localparam int INSTR_W = 24;
  localparam int PC_W = 23;
  localparam int DW = 16;
  localparam int RPT_W = 14;
  localparam int PSV_OFS_W = 15;
  localparam int PSV_PAGE_W = 8;

  // ============================================================
  // Instruction field positions
  localparam int OP_LSB = 20;
  localparam int FN_LSB = 16;
  localparam int WD_LSB = 12;
  localparam int WA_LSB = 8;
  localparam int WB_LSB = 4;
  localparam int LIT_WD_LSB = 16;
  localparam int SIGNED_BIT = 19;
  localparam int LONG_BIT = 18;
  localparam int MULMODE_LSB = 18;
  localparam int PSV_EN_BIT = 8;
  localparam int GOTO_TGT_W = 22;

  // ============================================================
  // Opcodes; a 2-bit prefix of all ones marks the long-target jump
  localparam logic [1:0] OP_GOTO_PFX = 2'h3;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ALU = 4'h1;
  localparam logic [3:0] OP_MOVL = 4'h2;
  localparam logic [3:0] OP_LD = 4'h3;
  localparam logic [3:0] OP_ST = 4'h4;
  localparam logic [3:0] OP_MUL = 4'h5;
  localparam logic [3:0] OP_SHF = 4'h6;
  localparam logic [3:0] OP_DIV = 4'h7;
  localparam logic [3:0] OP_RPT = 4'h8;
  localparam logic [3:0] OP_RETI = 4'h9;
  localparam logic [3:0] OP_MOVD = 4'ha;
  localparam logic [3:0] OP_PSV = 4'hb;

  localparam logic [3:0] FN_ADD = 4'h0;
  localparam logic [3:0] FN_SUB = 4'h1;
  localparam logic [3:0] FN_AND = 4'h2;
  localparam logic [3:0] FN_OR = 4'h3;
  localparam logic [3:0] FN_XOR = 4'h4;
  localparam logic [3:0] FN_MOV = 4'h5;

  localparam logic [1:0] MUL_SS = 2'h0;
  localparam logic [1:0] MUL_UU = 2'h1;
  localparam logic [1:0] MUL_US = 2'h2;
  localparam logic [1:0] MUL_SU = 2'h3;

  // ============================================================
  // Register roles, steps and reset values
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [3:0] QUOT_IDX = 4'h0;
  localparam logic [3:0] REM_IDX = 4'h1;
  localparam logic [PC_W-1:0] PC_RST = 23'h0;
  localparam logic [PC_W-1:0] PC_STEP = 23'h2;
  localparam logic [DW-1:0] WREG_RST = 16'h0;
  localparam logic [DW-1:0] WORD_STEP = 16'h2;
  localparam logic [DW-1:0] DBL_STEP = 16'h4;
  localparam logic [PSV_PAGE_W-1:0] PSV_PAGE_RST = 8'h0;
  localparam logic [DW-1:0] DMA_SIZE = 16'h0800;
  localparam logic [4:0] SHIFT_MAX = 5'h10;

  // ============================================================
  // Divide timing: load, one step per divisor bit, sign fix-up
  localparam logic [4:0] DIV_LAST = 5'h11;
  localparam logic [RPT_W-1:0] DIV_RPT_COUNT = 14'h0011;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_IRQ_HI,
    ST_RET_HI,
    ST_RET_LO,
    ST_MOVD_HI
  } cdp_state_t;

endpackage : cdp_pkg

/* dummy_end_marker_not_used.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* test_cpu_core_execution_datapath.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Program-driven bench; every store to the result address is compared
module test_cpu_core_execution_datapath;
  import cdp_pkg::*;
  localparam logic [DW-1:0] ST_ADDR = 16'h1000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic irqReq = 1'b0;
  logic [PC_W-1:0] irqVector = 23'h000600;
  logic [PC_W-1:0] progAddr;
  logic [INSTR_W-1:0] progRdData;
  logic [DW-1:0] dataRdAddr, dataRdData, dataWrAddr, dataWrData;
  logic dataRdEn, dataWrEn, dataDmaHit, irqAck, inIsr, rptActive, psvEnable;
  logic [PSV_PAGE_W-1:0] psvPage;
  integer seed = 32'h9eab;
  int miscompares = 0;
  int nCompared = 0;
  int nSeen = 0;
  int pc = 0;
  logic [DW-1:0] w [16];
  logic [DW-1:0] expQ [$];

  initial begin
    forever #2 clk = ~clk;
  end

  cdp_core u_cdp_core (.clk(clk), .rst_b(rst_b), .ce(ce), .progAddr(progAddr), .progRdData(progRdData),
    .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrAddr(dataWrAddr),
    .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataDmaHit(dataDmaHit), .irqReq(irqReq),
    .irqVector(irqVector), .irqAck(irqAck), .inIsr(inIsr), .rptActive(rptActive),
    .psvEnable(psvEnable), .psvPage(psvPage));
  cdp_mem_model u_cdp_mem_model (.clk(clk), .progAddr(progAddr), .progRdData(progRdData),
    .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrAddr(dataWrAddr),
    .dataWrData(dataWrData), .dataWrEn(dataWrEn));

  function automatic logic [DW-1:0] rnd();
    return DW'($random(seed));
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    nCompared++;
    if (seen !== expd) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask : check

  task automatic end_sim();
    if (miscompares == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Each word is followed by a free slot unless pad is cleared (the repeat word), so no result is read too early
  task automatic put(input logic [INSTR_W-1:0] ins, input bit pad = 1'b1);
    u_cdp_mem_model.prog[pc] = ins;
    pc = pc + (pad ? 2 : 1);
  endtask : put

  task automatic movl(input logic [3:0] r, input logic [DW-1:0] v);
    put({OP_MOVL, r, v});
    w[r] = v;
  endtask : movl

  task automatic st(input logic [3:0] r);
    put({OP_ST, r, 4'hc, 4'hd, 8'h0});
    expQ.push_back(w[r]);
  endtask : st

  task automatic build();
    logic [DW-1:0] a, b, dv, hi, lo;
    logic [31:0] p;
    longint n, dd;
    int amt [6] = '{3, 16, 0, 16, -16, -5};
    movl(4'hc, ST_ADDR);
    movl(4'hd, 16'h0);
    st(4'h9);
    movl(SP_IDX, 16'h0800);
    for (int f = 0; f < 6; f++) begin
      a = rnd();
      b = rnd();
      movl(4'h4, a);
      movl(4'h5, b);
      put({OP_ALU, 4'(f), 4'h6, 4'h4, 4'h5, 4'h0});
      case (f)
        0: w[6] = a + b;
        1: w[6] = a - b;
        2: w[6] = a & b;
        3: w[6] = a | b;
        4: w[6] = a ^ b;
        default: w[6] = a;
      endcase
      st(4'h6);
    end
    for (int m = 0; m < 4; m++) begin
      a = rnd();
      b = rnd();
      movl(4'h4, a);
      movl(4'h5, b);
      put({OP_MUL, 2'(m), 2'h0, 4'h2, 4'h4, 4'h5, 4'h0});
      p = ((2'(m) inside {MUL_SS, MUL_SU}) ? {{16{a[15]}}, a} : {16'h0, a})
        * ((2'(m) inside {MUL_SS, MUL_US}) ? {{16{b[15]}}, b} : {16'h0, b});
      w[2] = p[15:0];
      w[3] = p[31:16];
      st(4'h2);
      st(4'h3);
    end
    for (int k = 0; k < 6; k++) begin
      a = rnd() | 16'h8000;
      movl(4'h4, a);
      movl(4'h5, DW'(amt[k]));
      put({OP_SHF, k[1], 3'h0, 4'h6, 4'h4, 4'h5, 4'h0});
      n = (amt[k] < 0) ? -amt[k] : amt[k];
      if (amt[k] < 0) w[6] = a << n;
      else if (k[1]) w[6] = DW'($signed(a) >>> n);
      else w[6] = a >> n;
      st(4'h6);
    end
    for (int j = 0; j < 4; j++) begin
      dv = (rnd() & 16'h7fff) | 16'h1;
      lo = rnd();
      hi = j[1] ? (j[0] ? {16{lo[15]}} : rnd() % dv) : 16'h0;
      movl(4'h7, hi);
      movl(4'h6, lo);
      movl(4'h5, dv);
      put({OP_RPT, 6'h0, DIV_RPT_COUNT}, 1'b0);
      put({OP_DIV, j[0], j[1], 2'h0, 4'h6, 4'h5, 8'h0});
      if (j[1]) dd = j[0] ? longint'($signed({hi, lo})) : longint'({hi, lo});
      else dd = j[0] ? longint'($signed(lo)) : longint'(lo);
      w[0] = DW'(dd / longint'(dv));
      w[1] = DW'(dd % longint'(dv));
      st(4'h0);
      st(4'h1);
    end
    movl(4'ha, 16'h4000);
    for (int i = 0; i < 2; i++) begin
      movl(4'hb, i ? 16'h0800 : 16'h07fe);
      put({OP_LD, 4'h8, 4'ha, 4'hb, 8'h0});
      w[8] = (16'h4000 + w[11]) ^ 16'h5a5a;
      st(4'h8);
    end
    movl(4'h2, 16'h4000);
    put({OP_MOVD, 4'h0, 4'h2, 12'h0});
    w[2] = 16'h4000 ^ 16'h5a5a;
    w[3] = 16'h4002 ^ 16'h5a5a;
    st(4'h2);
    st(4'h3);
    put({OP_PSV, 11'h0, 1'b1, 8'ha5});
    // Upper-half read through the window lands on the low half of the first program word
    movl(4'ha, 16'h8000);
    movl(4'hb, 16'h0);
    put({OP_LD, 4'h8, 4'ha, 4'hb, 8'h0});
    w[8] = u_cdp_mem_model.prog[0][DW-1:0];
    st(4'h8);
    u_cdp_mem_model.prog[pc] = {OP_GOTO_PFX, 22'(pc)};
    u_cdp_mem_model.prog[32'h300] = {OP_RETI, 20'h0};
  endtask : build

  always @(posedge clk) begin
    ce <= (nSeen < 10) ? (($random(seed) & 3) != 0) : 1'b1;
    if (rst_b === 1'b1 && ce === 1'b1 && dataWrEn === 1'b1 && dataWrAddr === ST_ADDR) begin
      nSeen++;
      if (expQ.size() == 0) check(32'(dataWrData), 32'hffffffff);
      else check(32'(dataWrData), 32'(expQ.pop_front()));
    end
  end

  // One interrupt lands in the middle of the first divide loop
  initial begin
    @(posedge clk iff (rptActive === 1'b1 && nSeen >= 10));
    repeat (5) @(posedge clk);
    irqReq <= 1'b1;
    @(posedge clk iff irqAck === 1'b1);
    irqReq <= 1'b0;
  end

  initial begin
    for (int i = 0; i < 16; i++) w[i] = WREG_RST;
    build();
    repeat (2) @(posedge clk);
    check(32'({psvEnable, psvPage, progAddr}), 32'h0);
    rst_b <= 1'b1;
    for (int i = 0; i < 15000 && expQ.size() > 0; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    check(32'(expQ.size()), 32'h0);
    check(32'({psvEnable, psvPage}), 32'h1a5);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : test_cpu_core_execution_datapath
`default_nettype wire
